/* wwd_top.sv */
// windowed independent watchdog with register port
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module wwd_top
    import wwd_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,    // any reset, incl. watchdog reset
    input  wire logic        por_b_i,    // power-on reset only
    input  wire logic [31:0] option_i,   // option word from code flash
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        write_i,
    input  wire logic        read_i,
    output logic      [31:0] rdata_o,
    output logic             wdt_reset_o,
    output logic             nmi_o
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_s1;
    logic rst_b;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1 <= 1'b0;
            rst_b  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_b  <= rst_s1;
        end
    end
    logic por_s1;
    logic por_b;
    always_ff @(posedge clock_i or negedge por_b_i) begin
        if (!por_b_i) begin
            por_s1 <= 1'b0;
            por_b  <= 1'b0;
        end else begin
            por_s1 <= 1'b1;
            por_b  <= por_s1;
        end
    end

    // ****************************************
    // option word capture
    // ****************************************
    logic [31:0] option;
    logic        loaded;
    // option word latched once after each reset release
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            option <= OPTION_DEFAULT;
            loaded <= 1'b0;
        end else if (!loaded) begin
            option <= option_i;
            loaded <= 1'b1;
        end
    end
    logic            enabled;
    logic            resp_reset;
    logic [CNT_W-1:0] top;
    logic [CNT_W-1:0] win_hi;
    logic [CNT_W-1:0] win_lo;
    // counting starts one cycle after the load, once count holds the new top
    logic            started;
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            started <= 1'b0;
        end else begin
            started <= loaded;
        end
    end
    assign enabled    = started && !option[OPT_EN_BIT];
    assign resp_reset = option[OPT_RESP_BIT];
    // timeout length and window limits from option fields
    always_comb begin
        unique case (option[OPT_TOP_LSB +: 2])
            2'h0: top = TOP_1K;
            2'h1: top = TOP_4K;
            2'h2: top = TOP_8K;
            2'h3: top = TOP_16K;
        endcase
        // window start: counter value at or below which refresh opens
        unique case (option[OPT_WSTA_LSB +: 2])
            2'h0: win_hi = top;
            2'h1: win_hi = top - (top >> 2);
            2'h2: win_hi = top >> 1;
            2'h3: win_hi = top >> 2;
        endcase
        // window end: counter value below which refresh closes
        unique case (option[OPT_WEND_LSB +: 2])
            2'h0: win_lo = top - (top >> 2);
            2'h1: win_lo = top >> 1;
            2'h2: win_lo = top >> 2;
            2'h3: win_lo = '0;
        endcase
    end

    logic tick;
    wwd_prescale u_div (
        .clock_i (clock_i),
        .rst_b_i (rst_b),
        .sel_i   (option[OPT_DIV_LSB +: 2]),
        .tick_o  (tick)
    );

    // ****************************************
    // refresh key sequence and window check
    // ****************************************
    logic             armed;
    logic             refresh_ok;
    logic             refresh_bad;
    logic             in_window;
    logic [CNT_W-1:0] count;
    logic             wr_refresh;
    assign wr_refresh = write_i && (addr_i == ADDR_REFRESH);
    assign in_window  = (count <= win_hi) && (count >= win_lo);
    assign refresh_ok  = wr_refresh && armed && wdata_i == KEY_SECOND
                         && in_window && enabled;
    assign refresh_bad = wr_refresh && armed && wdata_i == KEY_SECOND
                         && !in_window && enabled;
    // first key arms, anything else disarms
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 1'b0;
        end else if (wr_refresh) begin
            armed <= (wdata_i == KEY_FIRST);
        end
    end

    // ****************************************
    // down counter
    // ****************************************
    logic expire;
    logic error;
    assign expire = enabled && tick && (count == '0);
    assign error  = expire || refresh_bad;
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            count <= TOP_16K;
        end else if (!enabled) begin
            count <= top;
        end else if (refresh_ok || error) begin
            count <= top;
        end else if (enabled && tick) begin
            count <= count - 1'b1;
        end
    end

    // ****************************************
    // error response
    // ****************************************
    logic [2:0] hold;
    // internal reset pulse of fixed length
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            hold <= 3'h0;
        end else if (error && resp_reset) begin
            hold <= 3'(RST_HOLD_CYC);
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end
    assign wdt_reset_o = (hold != 3'h0);

    // status flags only cleared by power-on reset or software
    logic nmi_flag;
    logic cause_flag;
    logic clr_nmi;
    logic clr_cause;
    assign clr_nmi   = write_i && addr_i == ADDR_NMI_STAT
                       && wdata_i[NMI_WDT_BIT];
    assign clr_cause = write_i && addr_i == ADDR_RST_STAT
                       && wdata_i[RST_WDT_BIT];
    always_ff @(posedge clock_i or negedge por_b) begin
        if (!por_b) begin
            nmi_flag <= 1'b0;
        end else if (error && !resp_reset) begin
            nmi_flag <= 1'b1;
        end else if (clr_nmi) begin
            nmi_flag <= 1'b0;
        end
    end
    always_ff @(posedge clock_i or negedge por_b) begin
        if (!por_b) begin
            cause_flag <= 1'b0;
        end else if (error) begin
            cause_flag <= 1'b1;
        end else if (clr_cause) begin
            cause_flag <= 1'b0;
        end
    end
    assign nmi_o = nmi_flag;

    // ****************************************
    // register read port
    // ****************************************
    always_ff @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            rdata_o <= 32'h0000_0000;
        end else if (read_i) begin
            unique case (addr_i)
                ADDR_NMI_STAT: rdata_o <= {31'h0, nmi_flag};
                ADDR_RST_STAT: rdata_o <= {31'h0, cause_flag};
                ADDR_COUNT:    rdata_o <= {18'h0, count};
                ADDR_OPTION:   rdata_o <= option;
                default:       rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // reset response: a fixed run of pulse cycles, then release
    sequence rst_pulse_s;
        wdt_reset_o [*4] ##1 !wdt_reset_o;
    endsequence
    expire_flag_a: assert property (@(posedge clock_i)
        disable iff (!rst_b) expire |=> cause_flag)
        else $error("expiry not flagged");
    early_err_a: assert property (@(posedge clock_i)
        disable iff (!rst_b)
        refresh_bad |=> cause_flag && count == $past(top))
        else $error("bad refresh missed");
    reset_resp_a: assert property (@(posedge clock_i)
        disable iff (!rst_b) error && resp_reset |=> rst_pulse_s)
        else $error("reset pulse wrong");
    nmi_resp_a: assert property (@(posedge clock_i)
        disable iff (!rst_b)
        error && !resp_reset |=> nmi_o && !wdt_reset_o)
        else $error("nmi not raised");
    reload_a: assert property (@(posedge clock_i)
        disable iff (!rst_b) refresh_ok |=> count == $past(top))
        else $error("refresh no reload");
    option_load_a: assert property (@(posedge clock_i)
        disable iff (!rst_b) $rose(loaded) |-> option == $past(option_i))
        else $error("option not loaded");
    idle_hold_a: assert property (@(posedge clock_i)
        disable iff (!rst_b)
        !enabled |=> count == $past(top) && !wdt_reset_o)
        else $error("count moved while stopped");
    flag_sticky_a: assert property (@(posedge clock_i)
        disable iff (!por_b) cause_flag && !clr_cause |=> cause_flag)
        else $error("cause flag lost");
endmodule
`default_nettype wire

/* wwd_pkg.sv */
// package of constants for the windowed independent watchdog
// Functional notes
// - flag an error when the counter expires without a refresh
// - refresh accepted only inside window; early refresh is an error too
// - on error assert internal reset or raise nmi, per configuration
// - all watchdog configuration comes from the option select word
// - option word in code flash is loaded after every reset
// - interrupt response sets watchdog bit in nmi status register
// - valid refresh reloads counter to start value
// - reset cause flag readable after reset shows watchdog caused it
package wwd_pkg;
    // ****************************************
    // register map (word offsets = byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_REFRESH  = 8'h00;
    localparam logic [7:0] ADDR_NMI_STAT = 8'h04;
    localparam logic [7:0] ADDR_RST_STAT = 8'h08;
    localparam logic [7:0] ADDR_COUNT    = 8'h0C;
    localparam logic [7:0] ADDR_OPTION   = 8'h10;
    // refresh needs two keys in sequence
    localparam logic [31:0] KEY_FIRST  = 32'h0000_0000;
    localparam logic [31:0] KEY_SECOND = 32'h0000_00FF;
    // ****************************************
    // option select word layout
    // ****************************************
    localparam int OPT_EN_BIT    = 0;  // 0 = watchdog running
    localparam int OPT_RESP_BIT  = 1;  // 1 = reset, 0 = nmi
    localparam int OPT_TOP_LSB   = 4;  // timeout selection, 2 bits
    localparam int OPT_WEND_LSB  = 8;  // window end, 2 bits
    localparam int OPT_WSTA_LSB  = 12; // window start, 2 bits
    localparam int OPT_DIV_LSB   = 16; // prescaler selection, 2 bits
    localparam logic [31:0] OPTION_DEFAULT = 32'hFFFF_FFFF;
    // window limits in percent of full count: 75,50,25,0 / 100,75,50,25
    localparam int CNT_W = 14;
    localparam logic [CNT_W-1:0] TOP_1K  = 14'h03FF;
    localparam logic [CNT_W-1:0] TOP_4K  = 14'h0FFF;
    localparam logic [CNT_W-1:0] TOP_8K  = 14'h1FFF;
    localparam logic [CNT_W-1:0] TOP_16K = 14'h3FFF;
    localparam int DIV_W = 8;
    // ****************************************
    // bits in the status words
    // ****************************************
    localparam int NMI_WDT_BIT = 0;   // watchdog nmi status bit
    localparam int RST_WDT_BIT = 0;   // watchdog reset cause
    localparam int RST_HOLD_CYC = 4;  // internal reset pulse length
endpackage

/* wwd_prescale.sv */
// prescaler issuing a one-cycle count enable
`timescale 1ns/1ps
`default_nettype none
module wwd_prescale
    import wwd_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    input  wire logic [1:0] sel_i,
    output logic            tick_o
);
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] lim;
    // divide by 1, 16, 64 or 256
    always_comb begin
        unique case (sel_i)
            2'h0: lim = 8'h00;
            2'h1: lim = 8'h0F;
            2'h2: lim = 8'h3F;
            2'h3: lim = 8'hFF;
        endcase
    end
    // free running counter
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 8'h00;
        end else if (cnt >= lim) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    assign tick_o = (cnt >= lim);
endmodule
`default_nettype wire

/* tb.sv */
// self-checking testbench for the windowed independent watchdog
`timescale 1ns/1ps
`default_nettype none
module tb
    import wwd_pkg::*;
;
    logic        clock_i;
    logic        rst_b_i;
    logic        por_b_i;
    logic [31:0] option_i;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i;
    logic        write_i;
    logic        read_i;
    logic [31:0] rdata_o;
    logic        wdt_reset_o;
    logic        nmi_o;
    logic [31:0] rd;
    int          error_cnt;
    int          check_count;
    int          n;

    wwd_top u_wwd_top (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .por_b_i     (por_b_i),
        .option_i    (option_i),
        .addr_i      (addr_i),
        .wdata_i     (wdata_i),
        .write_i     (write_i),
        .read_i      (read_i),
        .rdata_o     (rdata_o),
        .wdt_reset_o (wdt_reset_o),
        .nmi_o       (nmi_o)
    );

    // ****************************************
    // clock and helper tasks
    // ****************************************
    // free running 100 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // drive rst_b_i low, and por_b_i too when por is set, load an option word, release
    task automatic do_reset(input logic por, input logic [31:0] opt);
        @(posedge clock_i);
        rst_b_i  <= 1'b0;
        por_b_i  <= ~por;
        option_i <= opt;
        repeat (3) @(posedge clock_i);
        rst_b_i <= 1'b1;
        por_b_i <= 1'b1;
        repeat (4) @(posedge clock_i);
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clock_i);
        write_i <= 1'b0;
    endtask

    // one-cycle read strobe; data sampled in the following cycle
    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // read and compare in one call
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rdr(a, d);
        chk(d, exp);
    endtask

    // two-key refresh sequence
    task automatic refresh();
        wr(ADDR_REFRESH, KEY_FIRST);
        wr(ADDR_REFRESH, KEY_SECOND);
    endtask

    // print counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // watchdog against a hang
    // ****************************************
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        rst_b_i = 1'b0; por_b_i = 1'b0; option_i = 32'h0000_0000;
        addr_i = 8'h00; wdata_i = 32'h0000_0000;
        write_i = 1'b0; read_i = 1'b0;
        error_cnt = 0; check_count = 0;
        do_reset(1'b1, 32'h0000_0000);
        rchk(ADDR_NMI_STAT, 32'h0000_0000);
        rchk(ADDR_RST_STAT, 32'h0000_0000);
        rchk(ADDR_OPTION, 32'h0000_0000);
        rchk(8'h20, 32'h0000_0000);
        $display("test 1 done");
        // valid refresh reloads the count
        repeat (50) @(posedge clock_i);
        rdr(ADDR_COUNT, rd);
        chk({31'h0, rd < 32'h0000_03D0}, 32'h1);
        refresh();
        rdr(ADDR_COUNT, rd);
        chk({31'h0, rd >= 32'h0000_03FB}, 32'h1);
        chk({31'h0, nmi_o}, 32'h0);
        $display("test 2 done");
        // no refresh: expiry raises nmi and both flags
        n = 0;
        while (nmi_o !== 1'b1 && n < 1100) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk({31'h0, n > 1000 && n < 1100}, 32'h1);
        chk({31'h0, wdt_reset_o}, 32'h0);
        rchk(ADDR_NMI_STAT, 32'h0000_0001);
        rchk(ADDR_RST_STAT, 32'h0000_0001);
        $display("test 3 done");
        // flags survive an ordinary reset, cleared by software
        do_reset(1'b0, 32'h0000_0000);
        chk({31'h0, nmi_o}, 32'h1);
        rchk(ADDR_NMI_STAT, 32'h0000_0001);
        rchk(ADDR_RST_STAT, 32'h0000_0001);
        wr(ADDR_NMI_STAT, 32'h0000_0001);
        wr(ADDR_RST_STAT, 32'h0000_0001);
        rchk(ADDR_NMI_STAT, 32'h0000_0000);
        rchk(ADDR_RST_STAT, 32'h0000_0000);
        chk({31'h0, nmi_o}, 32'h0);
        $display("test 4 done");
        // early refresh with reset response and narrow window
        do_reset(1'b1, 32'h0000_3302);
        rchk(ADDR_OPTION, 32'h0000_3302);
        refresh();
        n = 0;
        while (wdt_reset_o !== 1'b1 && n < 10) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        // the pulse is already high here, so counting starts at one
        n = 1;
        while (wdt_reset_o === 1'b1 && n < 20) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk(n, RST_HOLD_CYC);
        chk({31'h0, nmi_o}, 32'h0);
        rchk(ADDR_RST_STAT, 32'h0000_0001);
        rchk(ADDR_NMI_STAT, 32'h0000_0000);
        $display("test 5 done");
        // power-on reset clears the cause flag; divide by 16 slows the count
        do_reset(1'b1, 32'h0001_0000);
        rchk(ADDR_RST_STAT, 32'h0000_0000);
        repeat (98) @(posedge clock_i);
        rdr(ADDR_COUNT, rd);
        chk({31'h0, rd > 32'h3F0 && rd < 32'h3FF}, 32'h1);
        $display("test 6 done");
        // a disabled watchdog holds its count and ignores refresh
        do_reset(1'b1, 32'h0000_0001);
        repeat (20) @(posedge clock_i);
        rchk(ADDR_COUNT, {18'h0, TOP_1K});
        refresh();
        rchk(ADDR_RST_STAT, 32'h0000_0000);
        chk({31'h0, nmi_o}, 32'h0);
        chk({31'h0, wdt_reset_o}, 32'h0);
        $display("test 7 done");
        summarize();
    end
endmodule
`default_nettype wire
